// ---- include/iev_consts.svh ----
`ifndef IEV_CONSTS_SVH
`define IEV_CONSTS_SVH

// ==========================================================
// register map
`define IEV_ADDR_MASK_PRIMARY 8'hA8
`define IEV_RST_MASK          8'h00
`define IEV_BITADDR_HI        7:3
`define IEV_BITADDR_SEL       2:0

// ==========================================================
// primary enable register bit positions
`define IEV_BIT_GATE   7
`define IEV_BIT_SPIA   6
`define IEV_BIT_TMR2   5
`define IEV_BIT_UART   4
`define IEV_BIT_TMR1   3
`define IEV_BIT_EXT1   2
`define IEV_BIT_TMR0   1
`define IEV_BIT_EXT0   0

// ==========================================================
// fixed source order
`define IEV_NUM_SRC    23
`define IEV_SRC_EXT0   0
`define IEV_SRC_TMR0   1
`define IEV_SRC_EXT1   2
`define IEV_SRC_TMR1   3
`define IEV_SRC_UART   4
`define IEV_SRC_TMR2   5
`define IEV_SRC_SPIA   6
`define IEV_SRC_MID_LO 7
`define IEV_SRC_MID_HI 16
`define IEV_SRC_OSC    17
`define IEV_SRC_SPIB   18
`define IEV_SRC_PULSE  19
`define IEV_SRC_DMA    20
`define IEV_SRC_ENC    21
`define IEV_SRC_AES    22
`define IEV_NUM_EXT    16

// ==========================================================
// vector formation: base plus eight bytes per source
`define IEV_VEC_BASE   16'h0003
`define IEV_VEC_SHIFT  3

`endif

// ---- include/iev_pkg.sv ----
package iev_pkg;

	typedef logic [4:0] iev_src_t;
	typedef logic [15:0] iev_vec_t;

	// service level currently running on the core
	typedef enum logic [3:0] {
		IEV_IDLE     = 4'b0001,
		IEV_LOW      = 4'b0010,
		IEV_HIGH     = 4'b0100,
		IEV_HIGH_PRE = 4'b1000
	} iev_level_e;

endpackage

// ---- logic/iev_arbiter.sv ----
`timescale 1ns/1ns
module iev_arbiter
	import iev_pkg::*;
#(
	parameter int N = 23
) (
	input  wire logic [N-1:0] req,
	output logic              found,
	output iev_src_t          idx
);

	// lowest index wins, matching the fixed source order
	always_comb begin
		found = 1'b0;
		idx   = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx   = iev_src_t'(i);
			end
		end
	end

endmodule // iev_arbiter

// ---- logic/iev_top.sv ----
`timescale 1ns/1ns
`include "iev_consts.svh"
module iev_top
	import iev_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [7:0]               sfr_addr,
	input  wire logic                     sfr_wr,
	input  wire logic                     sfr_rd,
	input  wire logic [7:0]               sfr_wdata,
	output logic      [7:0]               sfr_rdata_q,
	input  wire logic [7:0]               bit_addr,
	input  wire logic                     bit_wr,
	input  wire logic                     bit_wdata,
	input  wire logic                     ext_line_zero_pend,
	input  wire logic                     timer_zero_overflow,
	input  wire logic                     ext_line_one_pend,
	input  wire logic                     timer_one_overflow,
	input  wire logic                     async_serial_port_pend,
	input  wire logic                     timer_two_low_overflow,
	input  wire logic                     timer_two_high_overflow,
	input  wire logic                     serial_port_a_pend,
	input  wire logic [9:0]               mid_src_pend,
	input  wire logic                     lf_oscillator_failure_flag,
	input  wire logic                     transfer_done_flag,
	input  wire logic                     write_collision_flag,
	input  wire logic                     mode_fault_flag,
	input  wire logic                     receive_overrun_flag,
	input  wire logic                     pulse_counter_pend,
	input  wire logic                     dma_pend,
	input  wire logic                     encoder_pend,
	input  wire logic                     cipher_pend,
	input  wire logic [`IEV_NUM_EXT-1:0]  ext_irq_mask,
	input  wire logic [`IEV_NUM_SRC-1:0]  src_high_prio,
	input  wire logic                     core_ack,
	input  wire logic                     core_reti,
	output logic                          irq_req_q,
	output iev_vec_t                      irq_vector_q,
	output iev_src_t                      irq_src_q,
	output logic                          irq_high_q,
	output logic      [7:0]               mask_primary_q
);

	// ==========================================================
	// register access
	function automatic logic is_mask_bit(input logic [7:0] a);
		is_mask_bit = (a[`IEV_BITADDR_HI] == 5'(`IEV_ADDR_MASK_PRIMARY >> 3));
	endfunction

	logic [7:0] mask_d;
	logic [7:0] rdata_d;
	logic       byte_hit;
	logic       bit_hit;
	logic [7:0] bit_sel;

	// page select is ignored so the register is seen on every page
	assign byte_hit = (sfr_addr == `IEV_ADDR_MASK_PRIMARY);
	assign bit_hit  = bit_wr && is_mask_bit(bit_addr);
	assign bit_sel  = 8'h01 << bit_addr[`IEV_BITADDR_SEL];

	always_comb begin
		mask_d = mask_primary_q;
		if (sfr_wr && byte_hit) begin
			mask_d = sfr_wdata;
		end else if (bit_hit) begin
			mask_d = bit_wdata ? (mask_primary_q | bit_sel) : (mask_primary_q & ~bit_sel);
		end
	end

	// unmapped reads answer zero
	assign rdata_d = (sfr_rd && byte_hit) ? mask_primary_q : 8'h00;

	// ==========================================================
	// source gating
	logic [`IEV_NUM_SRC-1:0] pend;
	logic [`IEV_NUM_SRC-1:0] mask;
	logic [`IEV_NUM_SRC-1:0] armed;
	logic                    gate;

	assign gate = mask_primary_q[`IEV_BIT_GATE];

	// software-set flags arrive on the same inputs, so they vector identically
	assign pend[`IEV_SRC_EXT0] = ext_line_zero_pend;
	assign pend[`IEV_SRC_TMR0] = timer_zero_overflow;
	assign pend[`IEV_SRC_EXT1] = ext_line_one_pend;
	assign pend[`IEV_SRC_TMR1] = timer_one_overflow;
	assign pend[`IEV_SRC_UART] = async_serial_port_pend;
	assign pend[`IEV_SRC_TMR2] = timer_two_low_overflow | timer_two_high_overflow;
	assign pend[`IEV_SRC_SPIA] = serial_port_a_pend;
	assign pend[`IEV_SRC_MID_HI:`IEV_SRC_MID_LO] = mid_src_pend;
	// flag is read over the indirect space bridge, not a direct register
	assign pend[`IEV_SRC_OSC]  = lf_oscillator_failure_flag;
	// flags are level inputs owned by the port; nothing here clears them
	assign pend[`IEV_SRC_SPIB] = transfer_done_flag | write_collision_flag
		| mode_fault_flag | receive_overrun_flag;
	assign pend[`IEV_SRC_PULSE] = pulse_counter_pend;
	assign pend[`IEV_SRC_DMA]   = dma_pend;
	assign pend[`IEV_SRC_ENC]   = encoder_pend;
	assign pend[`IEV_SRC_AES]   = cipher_pend;

	assign mask[`IEV_SRC_EXT0] = mask_primary_q[`IEV_BIT_EXT0];
	assign mask[`IEV_SRC_TMR0] = mask_primary_q[`IEV_BIT_TMR0];
	assign mask[`IEV_SRC_EXT1] = mask_primary_q[`IEV_BIT_EXT1];
	assign mask[`IEV_SRC_TMR1] = mask_primary_q[`IEV_BIT_TMR1];
	assign mask[`IEV_SRC_UART] = mask_primary_q[`IEV_BIT_UART];
	assign mask[`IEV_SRC_TMR2] = mask_primary_q[`IEV_BIT_TMR2];
	assign mask[`IEV_SRC_SPIA] = mask_primary_q[`IEV_BIT_SPIA];
	// read-only flags are silenced through these mask bits or the gate bit
	assign mask[`IEV_SRC_AES:`IEV_SRC_MID_LO] = ext_irq_mask;

	assign armed = gate ? (pend & mask) : '0;

	// ==========================================================
	// arbitration
	iev_level_e level_q;
	iev_level_e level_d;
	logic       hi_found;
	logic       lo_found;
	iev_src_t   hi_idx;
	iev_src_t   lo_idx;
	logic       allow_hi;
	logic       allow_lo;
	logic       take_hi;
	logic       take_lo;
	logic       req_d;
	iev_src_t   src_d;
	iev_vec_t   vec_d;

	iev_arbiter #(
		.N (`IEV_NUM_SRC)
	) u_arb_hi (
		.req   (armed & src_high_prio),
		.found (hi_found),
		.idx   (hi_idx)
	);

	iev_arbiter #(
		.N (`IEV_NUM_SRC)
	) u_arb_lo (
		.req   (armed & ~src_high_prio),
		.found (lo_found),
		.idx   (lo_idx)
	);

	// a high routine blocks everything; a low routine admits only high
	assign allow_hi = (level_q == IEV_IDLE) || (level_q == IEV_LOW);
	assign allow_lo = (level_q == IEV_IDLE);
	assign take_hi  = allow_hi && hi_found;
	assign take_lo  = allow_lo && lo_found && !take_hi;
	// drop the request in the ack cycle so the taken source is not offered twice
	assign req_d    = (take_hi || take_lo) && !(core_ack && irq_req_q);
	assign src_d    = take_hi ? hi_idx : lo_idx;
	// vector table is a fixed stride, so the address is formed rather than stored
	assign vec_d    = iev_vec_t'(`IEV_VEC_BASE + (iev_vec_t'(src_d) << `IEV_VEC_SHIFT));

	always_comb begin
		level_d = level_q;
		if (core_reti) begin
			unique case (level_q)
				IEV_IDLE:     level_d = IEV_IDLE;
				IEV_LOW:      level_d = IEV_IDLE;
				IEV_HIGH:     level_d = IEV_IDLE;
				IEV_HIGH_PRE: level_d = IEV_LOW;
				default:      level_d = IEV_IDLE;
			endcase
		end else if (core_ack && irq_req_q) begin
			unique case (level_q)
				IEV_IDLE:     level_d = irq_high_q ? IEV_HIGH : IEV_LOW;
				IEV_LOW:      level_d = irq_high_q ? IEV_HIGH_PRE : IEV_LOW;
				IEV_HIGH:     level_d = IEV_HIGH;
				IEV_HIGH_PRE: level_d = IEV_HIGH_PRE;
				default:      level_d = IEV_IDLE;
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_primary_q <= `IEV_RST_MASK;
			sfr_rdata_q    <= 8'h00;
			level_q        <= IEV_IDLE;
			irq_req_q      <= 1'b0;
			irq_src_q      <= '0;
			irq_high_q     <= 1'b0;
			irq_vector_q   <= '0;
		end else begin
			mask_primary_q <= mask_d;
			sfr_rdata_q    <= rdata_d;
			level_q        <= level_d;
			irq_req_q      <= req_d;
			irq_src_q      <= src_d;
			irq_high_q     <= take_hi;
			irq_vector_q   <= vec_d;
		end
	end

endmodule // iev_top

// ---- testbench/iev_top_sva.sv ----
`timescale 1ns/1ns
module iev_top_sva
	import iev_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata_q,
	input wire logic       core_ack,
	input wire logic       irq_req_q,
	input iev_vec_t        irq_vector_q,
	input iev_src_t        irq_src_q,
	input wire logic [7:0] mask_primary_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==========
	// register port
	a_byte_write: assert property (
		sfr_wr && sfr_addr == 8'hA8 |=> mask_primary_q == $past(sfr_wdata))
		else $error("byte write not taken");
	a_read_back: assert property (
		sfr_rd && !sfr_wr && sfr_addr == 8'hA8 |=> sfr_rdata_q == $past(mask_primary_q))
		else $error("read data differs from mask");
	a_read_other: assert property (
		sfr_rd && sfr_addr != 8'hA8 |=> sfr_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_pulse: assert property (
		sfr_rdata_q != 8'h00 |-> $past(sfr_rd))
		else $error("read data without read");
	// reset check must run while reset is high
	a_reset_clear: assert property (disable iff (1'b0)
		rst |=> !irq_req_q && mask_primary_q == 8'h00 && sfr_rdata_q == 8'h00)
		else $error("reset left state");
	// ==========
	// core link
	a_gate_off: assert property (
		!mask_primary_q[7] |=> !irq_req_q)
		else $error("request with gate closed");
	a_ack_drop: assert property (
		core_ack && irq_req_q |=> !irq_req_q)
		else $error("request held after accept");
	a_vector_form: assert property (
		irq_req_q |-> irq_vector_q == 16'h0003 + {8'h00, irq_src_q, 3'b000})
		else $error("vector does not match source");
	c_accept: cover property (core_ack && irq_req_q);
	c_port_b: cover property (irq_req_q && irq_src_q == 5'd18);
	c_read: cover property (sfr_rd && sfr_addr == 8'hA8);
endmodule // iev_top_sva

bind iev_top iev_top_sva i_iev_top_sva (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
	.core_ack(core_ack), .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
	.irq_src_q(irq_src_q), .mask_primary_q(mask_primary_q));

// ---- testbench/iev_core_model.sv ----
`timescale 1ns/1ns
module iev_core_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic irq_req_q,
	input  wire logic ack_en,
	input  wire logic reti_go,
	output logic      core_ack,
	output logic      core_reti
);
	// one pulse per request; a held ack would accept a stale one
	always_ff @(posedge clk) begin
		if (rst) begin
			core_ack  <= 1'b0;
			core_reti <= 1'b0;
		end else begin
			core_ack  <= ack_en && irq_req_q && !core_ack;
			core_reti <= reti_go;
		end
	end
endmodule // iev_core_model

// ---- testbench/iev_top_bench.sv ----
`timescale 1ns/1ns
module iev_top_bench;
	logic        clk, rst, sfr_wr, sfr_rd, bit_wr, bit_wdata, ack_en, reti_go;
	logic        core_ack, core_reti, irq_req_q, irq_high_q;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, bit_addr, mask_primary_q, pend, v;
	logic [15:0] ext_p, emask, irq_vector_q;
	logic [22:0] prio;
	logic [4:0]  irq_src_q;
	logic [3:0]  sb;
	int          n_fail, checks_done;

	initial begin clk = 1'b0; forever #5 clk = ~clk; end

	iev_top i_iev_top (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
		.bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata),
		.ext_line_zero_pend(pend[0]), .timer_zero_overflow(pend[1]),
		.ext_line_one_pend(pend[2]), .timer_one_overflow(pend[3]),
		.async_serial_port_pend(pend[4]), .timer_two_low_overflow(pend[5]),
		.serial_port_a_pend(pend[6]), .timer_two_high_overflow(pend[7]),
		.mid_src_pend(ext_p[9:0]), .lf_oscillator_failure_flag(ext_p[10]),
		.transfer_done_flag(sb[0]), .write_collision_flag(sb[1]),
		.mode_fault_flag(sb[2]), .receive_overrun_flag(sb[3]),
		.pulse_counter_pend(ext_p[12]), .dma_pend(ext_p[13]),
		.encoder_pend(ext_p[14]), .cipher_pend(ext_p[15]), .ext_irq_mask(emask),
		.src_high_prio(prio), .core_ack(core_ack), .core_reti(core_reti),
		.irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q), .irq_src_q(irq_src_q),
		.irq_high_q(irq_high_q), .mask_primary_q(mask_primary_q));

	iev_core_model i_iev_core_model (.clk(clk), .rst(rst), .irq_req_q(irq_req_q),
		.ack_en(ack_en), .reti_go(reti_go), .core_ack(core_ack), .core_reti(core_reti));

	// ==========
	// tasks
	task automatic wrap_up();
		if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk); sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
		@(negedge clk); sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk); sfr_addr = a; sfr_rd = 1'b1;
		@(negedge clk); sfr_rd = 1'b0; d = sfr_rdata_q;
	endtask
	task automatic bw(input logic [2:0] k, input logic b);
		@(negedge clk); bit_addr = {5'h15, k}; bit_wdata = b; bit_wr = 1'b1;
		@(negedge clk); bit_wr = 1'b0;
	endtask
	// raise flags, look at the request, then drop them
	task automatic sw(input logic [7:0] p, input logic [15:0] x, input logic [3:0] s,
		input logic [4:0] e, input logic q);
		@(negedge clk); pend = p; ext_p = x; sb = s;
		repeat (2) @(negedge clk);
		chk("req", {15'h0, q}, {15'h0, irq_req_q});
		if (q) begin
			chk("src", {11'h0, e}, {11'h0, irq_src_q});
			chk("vec", 16'h0003 + {8'h00, e, 3'b000}, irq_vector_q);
		end
		pend = 8'h00; ext_p = 16'h0000; sb = 4'h0; @(negedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up();
	end

	// ==========
	// tests
	initial begin
		rst = 1'b1; {sfr_wr, sfr_rd, bit_wr, bit_wdata, ack_en, reti_go} = 6'h00;
		sfr_addr = 8'h00; sfr_wdata = 8'h00; bit_addr = 8'h00; pend = 8'h00;
		ext_p = 16'h0000; sb = 4'h0; emask = 16'hFFFF; prio = 23'h0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		chk("mask", 16'h0000, {8'h00, mask_primary_q});
		wr(8'hA8, 8'hA5); rd(8'hA8, v); chk("rd", 16'h00A5, {8'h00, v});
		rd(8'hB8, v); chk("unmapped", 16'h0000, {8'h00, v});
		wr(8'hA8, 8'h00);
		for (int k = 0; k < 8; k++) begin
			bw(3'(k), 1'b1);
			chk("bit", (16'h0002 << k) - 16'h0001, {8'h00, mask_primary_q});
		end
		bw(3'd7, 1'b0);
		chk("bitclr", 16'h007F, {8'h00, mask_primary_q});
		for (int i = 0; i < 7; i++) begin
			wr(8'hA8, 8'h80 | (8'h01 << i));
			sw(8'h01 << i, 16'h0, 4'h0, 5'(i), 1'b1);
			wr(8'hA8, 8'h7F); sw(8'h01 << i, 16'h0, 4'h0, 5'd0, 1'b0);
			wr(8'hA8, ~(8'h01 << i)); sw(8'h01 << i, 16'h0, 4'h0, 5'd0, 1'b0);
		end
		wr(8'hA8, 8'hA0); sw(8'h80, 16'h0, 4'h0, 5'd5, 1'b1);
		wr(8'hA8, 8'h80);
		for (int j = 0; j < 16; j++)
			if (j != 11) sw(8'h00, 16'h0001 << j, 4'h0, 5'(j + 7), 1'b1);
		for (int k = 0; k < 4; k++) sw(8'h00, 16'h0, 4'h1 << k, 5'd18, 1'b1);
		emask = 16'h0000; sw(8'h00, 16'h0400, 4'hF, 5'd0, 1'b0);
		wr(8'hA8, 8'h83); sw(8'h03, 16'h0, 4'h0, 5'd0, 1'b1);
		prio = 23'h2; sw(8'h03, 16'h0, 4'h0, 5'd1, 1'b1);
		// low routine, then a high one preempts it and cannot itself be preempted
		wr(8'hA8, 8'h86); prio = 23'h4; ack_en = 1'b1; pend = 8'h02;
		repeat (4) @(negedge clk);
		chk("low", 16'h0, {15'h0, irq_req_q});
		ack_en = 1'b0; pend = 8'h06; repeat (2) @(negedge clk);
		chk("pre", 16'h0002, {11'h0, irq_src_q});
		chk("prereq", 16'h0001, {15'h0, irq_req_q});
		chk("high", 16'h0001, {15'h0, irq_high_q});
		ack_en = 1'b1; repeat (3) @(negedge clk); ack_en = 1'b0;
		chk("nest", 16'h0, {15'h0, irq_req_q});
		// high flag gone: its return must fall back to the low routine, not to idle
		pend = 8'h02;
		reti_go = 1'b1; @(negedge clk); reti_go = 1'b0; repeat (3) @(negedge clk);
		chk("resume", 16'h0000, {15'h0, irq_req_q});
		reti_go = 1'b1; @(negedge clk); reti_go = 1'b0; repeat (3) @(negedge clk);
		chk("idle", 16'h0001, {15'h0, irq_req_q});
		chk("again", 16'h0001, {11'h0, irq_src_q});
		wrap_up();
	end
endmodule // iev_top_bench
